// ===== fftm_assertions.sv
`timescale 1ns/1ps

// **********
// Flag checker
// **********
module fftm_assertions (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wclk,
    input wire logic rclk,
    input wire logic mode_select_serial_in,
    input wire logic empty_flag,
    input wire logic full_flag,
    input wire logic output_ready_n,
    input wire logic input_ready_n,
    input wire logic almost_empty_flag,
    input wire logic half_full_flag,
    input wire logic almost_full_flag
);
    logic       fall_through_mode_r;
    logic [1:0] wp_r;
    logic [1:0] rp_r;
    logic [2:0] w_age_r;
    logic [2:0] r_age_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    always_ff @(posedge mclk) begin
        if (srst) fall_through_mode_r <= mode_select_serial_in;
    end

    // Age since a pin clock rise; empty, full and output-ready flags move only just after one
    always_ff @(posedge mclk) begin
        wp_r    <= {wp_r[0], wclk};
        w_age_r <= (wp_r == 2'b01) ? 3'h0 : w_age_r + {2'h0, w_age_r != 3'h7};
    end
    always_ff @(posedge mclk) begin
        rp_r    <= {rp_r[0], rclk};
        r_age_r <= (rp_r == 2'b01) ? 3'h0 : r_age_r + {2'h0, r_age_r != 3'h7};
    end

    sequence s_rel; $fell(srst); endsequence
    property p_rst_idle; s_rel |-> !empty_flag && full_flag && output_ready_n && !input_ready_n
        && !almost_empty_flag && half_full_flag && almost_full_flag; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("flags not idle after reset");
    property p_std_idle; !fall_through_mode_r |-> output_ready_n && !input_ready_n; endproperty
    a_std_idle: assert property (p_std_idle) else $error("ready pins active");
    property p_fall_through_mode_idle; fall_through_mode_r |-> !empty_flag && full_flag; endproperty
    a_fall_through_mode_idle: assert property (p_fall_through_mode_idle) else $error("empty/full active");
    property p_full_top; !full_flag |-> !almost_full_flag && !half_full_flag; endproperty
    a_full_top: assert property (p_full_top) else $error("full without thresholds");
    property p_empty_low; !fall_through_mode_r && !empty_flag |-> half_full_flag && almost_full_flag; endproperty
    a_empty_low: assert property (p_empty_low) else $error("empty with high levels");
    property p_paf_hf; !almost_full_flag |-> !half_full_flag; endproperty
    a_paf_hf: assert property (p_paf_hf) else $error("almost full above half");
    property p_hf_pae; !half_full_flag |-> almost_empty_flag; endproperty
    a_hf_pae: assert property (p_hf_pae) else $error("half full yet almost empty");
    property p_ef_sync; $changed(empty_flag) |-> r_age_r <= 3'h4; endproperty
    a_ef_sync: assert property (p_ef_sync) else $error("empty off read clock");
    property p_ff_sync; $changed(full_flag) |-> w_age_r <= 3'h4; endproperty
    a_ff_sync: assert property (p_ff_sync) else $error("full off write clock");
    property p_or_sync; $changed(output_ready_n) |-> r_age_r <= 3'h4; endproperty
    a_or_sync: assert property (p_or_sync) else $error("ready off read clock");
endmodule

bind fftm_top fftm_assertions u_chk (.*);

// ===== fftm_axil_slave.sv
`timescale 1ns/1ps
`include "fftm_params.svh"

module fftm_axil_slave (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire fftm_pkg::fftm_addr_t s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire fftm_pkg::fftm_addr_t s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    fftm_reg_if.bus                 regs
);
    import fftm_pkg::*;

    logic        aw_got_r;
    logic        w_got_r;
    logic        rd_pend_r;
    fftm_addr_t  waddr_r;
    fftm_addr_t  raddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;

    // Write fires once both halves are held and no response is pending
    assign regs.wr_stb  = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign regs.wr_addr = waddr_r;
    assign regs.wr_data = wdata_r;
    assign regs.wr_strb = wstrb_r;
    assign regs.rd_addr = raddr_r;

    // ****************************************************************
    // Write address, data and response
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FFTM_RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            waddr_r       <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_r       <= s_axi_awaddr;
                aw_got_r      <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (!aw_got_r && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (!w_got_r && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (regs.wr_stb) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= regs.wr_err ? `FFTM_RESP_SLVERR : `FFTM_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read address and data
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `FFTM_RESP_OKAY;
            rd_pend_r     <= 1'b0;
            raddr_r       <= 8'h00;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                raddr_r       <= s_axi_araddr;
                rd_pend_r     <= 1'b1;
                s_axi_arready <= 1'b0;
            end else if (!rd_pend_r && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
            if (rd_pend_r) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= regs.rd_data;
                s_axi_rresp  <= regs.rd_err ? `FFTM_RESP_SLVERR : `FFTM_RESP_OKAY;
                rd_pend_r    <= 1'b0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ===== fftm_far_end.sv
`timescale 1ns/1ps

// **********
// Producer and consumer pins
// **********
module fftm_far_end (
    input  wire logic            mclk,
    output logic                 wclk,
    output logic                 rclk,
    output logic                 wen_n,
    output logic                 ren_n,
    output fftm_pkg::fftm_word_t din
);
    import fftm_pkg::*;
    fftm_word_t wq[$];
    int         rd_pend = 0;
    logic [2:0] wc_r = 3'h0;
    logic [2:0] rc_r = 3'h3;

    // Free-running pin clocks, 4 mclk per phase
    assign wclk = wc_r[2];
    assign rclk = rc_r[2];
    initial begin
        wen_n = 1'b1;
        ren_n = 1'b1;
        din   = '0;
    end
    always @(posedge mclk) begin
        wc_r <= wc_r + 3'h1;
        rc_r <= rc_r + 3'h1;
    end
    // Enables move mid-low; idle data toggles to expose stale reads
    always @(posedge mclk) begin
        if (wc_r == 3'h1) begin
            wen_n <= (wq.size() == 0);
            din   <= (wq.size() != 0) ? wq.pop_front() : ~din;
        end
        if (rc_r == 3'h1) begin
            ren_n   <= (rd_pend == 0);
            if (rd_pend != 0) rd_pend <= rd_pend - 1;
        end
    end
endmodule

// ===== fftm_params.svh
`ifndef FFTM_PARAMS_SVH
`define FFTM_PARAMS_SVH

// ****************************************************************
// Widths and depths
// ****************************************************************
`define FFTM_DW          18
`define FFTM_D9W         9
`define FFTM_AW          12
`define FFTM_CW          13
`define FFTM_DEPTH_X18   13'h0800
`define FFTM_DEPTH_X9    13'h1000

// ****************************************************************
// Pin synchroniser layout
// ****************************************************************
`define FFTM_SY_W        24
`define FFTM_SY_WCLK     0
`define FFTM_SY_WEN      1
`define FFTM_SY_DIN      2
`define FFTM_SY_RCLK     20
`define FFTM_SY_REN      21
`define FFTM_SY_MODE     22
`define FFTM_SY_BUS9     23

// ****************************************************************
// Register map
// ****************************************************************
`define FFTM_REG_OFFS    8'h00
`define FFTM_REG_STAT    8'h04
`define FFTM_OFFS_DEF    13'h007F
`define FFTM_RESP_OKAY   2'h0
`define FFTM_RESP_SLVERR 2'h2

`endif

// ===== fftm_pkg.sv
`include "fftm_params.svh"

package fftm_pkg;

    typedef enum logic {
        FFTM_MODE_STD,
        FFTM_MODE_FALL_THROUGH_MODE
    } fftm_mode_e;

    typedef logic [`FFTM_CW-1:0] fftm_cnt_t;
    typedef logic [`FFTM_AW-1:0] fftm_ptr_t;
    typedef logic [`FFTM_DW-1:0] fftm_word_t;
    typedef logic [7:0]          fftm_addr_t;

endpackage

// ===== fftm_reg_if.sv
`timescale 1ns/1ps

interface fftm_reg_if;
    import fftm_pkg::*;

    logic        wr_stb;
    fftm_addr_t  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    fftm_addr_t  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;

    modport bus  (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                  input  wr_err, rd_data, rd_err);
    modport core (input  wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_err, rd_data, rd_err);

endinterface

// ===== fftm_top.sv
`timescale 1ns/1ps
`include "fftm_params.svh"

// Operation
// - Mode strap sampled during reset; low standard, high fall-through, held until next reset.
// - Standard mode: empty flag shows data stored, full flag shows space left.
// - Fall-through mode: output-ready shows valid output word, input-ready shows space.
// - Fall-through: first word into empty FIFO appears after three read clock edges.
// - Writer holds write enable low; word captured on each qualifying write edge.
// - Standard mode empty flag rises once first write into empty FIFO completes.
// - Standard mode almost-empty rises when stored count reaches offset n plus one.
// - Standard mode half-full falls when stored count reaches half depth plus one.
// - Standard mode almost-full falls when stored count reaches depth minus offset m.
// - Standard mode full flag falls at depth words; further writes then ignored.
// - Depth is base capacity for 18-bit ports, doubled when both ports 9-bit.
// - Standard mode: first read from full FIFO returns full flag high.
// - Reads raise almost-full and half-full again at the same count thresholds.
// - Standard mode almost-empty falls when stored count drops to offset n.
// - Standard mode empty flag falls after last word is read, blocking reads.
// - Read enable ignored while empty; read pointer and outputs stay unchanged.
// - Standard mode empty and full flags pass through two register stages.
// - Fall-through: almost-empty rises at n plus two; output register adds capacity.
// - Fall-through: output-ready passes three stages, input-ready passes two stages.
module fftm_top (
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire fftm_pkg::fftm_addr_t s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire fftm_pkg::fftm_addr_t s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 wclk,
    input  wire logic                 wen_n,
    input  wire fftm_pkg::fftm_word_t din,
    input  wire logic                 rclk,
    input  wire logic                 ren_n,
    output fftm_pkg::fftm_word_t      dout,
    input  wire logic                 mode_select_serial_in,
    input  wire logic                 bus9_select,
    output logic                      empty_flag,
    output logic                      full_flag,
    output logic                      output_ready_n,
    output logic                      input_ready_n,
    output logic                      almost_empty_flag,
    output logic                      half_full_flag,
    output logic                      almost_full_flag
);
    import fftm_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic fftm_ptr_t ptr_step(input fftm_ptr_t ptr, input fftm_cnt_t depth);
        fftm_cnt_t last;
        last = depth - 13'h0001;
        return (ptr == last[`FFTM_AW-1:0]) ? 12'h000 : ptr + 12'h001;
    endfunction

    // Fall-through counts one more word for the output register
    function automatic fftm_cnt_t thr(input fftm_cnt_t base, input logic extra);
        return base + {{(`FFTM_CW-1){1'b0}}, extra};
    endfunction

    fftm_reg_if regs ();

    logic [`FFTM_SY_W-1:0] sy1_r;
    logic [`FFTM_SY_W-1:0] sy2_r;
    logic [`FFTM_SY_W-1:0] sy3_r;
    logic                  wclk_lvl_r;
    logic                  rclk_lvl_r;
    logic                  w_ev;
    logic                  r_ev;
    fftm_mode_e            mode_r;
    logic                  bus9_r;
    logic                  fw;
    fftm_cnt_t             depth;
    fftm_word_t            mem [0:`FFTM_DEPTH_X9-1];
    fftm_ptr_t             wptr_r;
    fftm_ptr_t             rptr_r;
    fftm_cnt_t             mem_cnt_r;
    fftm_cnt_t             tot;
    fftm_cnt_t             n_r;
    fftm_cnt_t             m_r;
    logic                  mem_ne;
    logic                  full_lvl;
    logic                  wr_do;
    logic                  rd_do;
    logic                  ne_s1_r;
    logic                  ne_s2_r;
    logic                  ef1_r;
    logic                  ff1_r;
    logic                  ir1_r;
    fftm_word_t            din_w;

    // ****************************************************************
    // Pin synchronisers and clock edge events
    // ****************************************************************
    // No reset here so the strap levels reach stage three during reset
    always_ff @(posedge mclk) begin
        sy1_r <= {bus9_select, mode_select_serial_in, ren_n, rclk, din, wen_n, wclk};
        sy2_r <= sy1_r;
        sy3_r <= sy2_r;
    end

    // Edge counts once stages two and three agree on the new level
    always_ff @(posedge mclk) begin
        if (srst) begin
            // Follow the pin in reset so release gives no false edge
            wclk_lvl_r <= sy3_r[`FFTM_SY_WCLK];
            rclk_lvl_r <= sy3_r[`FFTM_SY_RCLK];
        end else begin
            if (sy2_r[`FFTM_SY_WCLK] == sy3_r[`FFTM_SY_WCLK]) begin
                wclk_lvl_r <= sy3_r[`FFTM_SY_WCLK];
            end
            if (sy2_r[`FFTM_SY_RCLK] == sy3_r[`FFTM_SY_RCLK]) begin
                rclk_lvl_r <= sy3_r[`FFTM_SY_RCLK];
            end
        end
    end

    assign w_ev = sy2_r[`FFTM_SY_WCLK] & sy3_r[`FFTM_SY_WCLK] & ~wclk_lvl_r;
    assign r_ev = sy2_r[`FFTM_SY_RCLK] & sy3_r[`FFTM_SY_RCLK] & ~rclk_lvl_r;

    // ****************************************************************
    // Reset straps
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_r <= sy3_r[`FFTM_SY_MODE] ? FFTM_MODE_FALL_THROUGH_MODE : FFTM_MODE_STD;
            bus9_r <= sy3_r[`FFTM_SY_BUS9];
        end
    end

    assign fw    = (mode_r == FFTM_MODE_FALL_THROUGH_MODE);
    assign depth = bus9_r ? `FFTM_DEPTH_X9 : `FFTM_DEPTH_X18;

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    assign tot      = thr(mem_cnt_r, fw & ~output_ready_n);
    assign mem_ne   = (mem_cnt_r != 13'h0000);
    assign full_lvl = (tot >= thr(depth, fw));
    // Acceptance uses the live count, not the lagging flag, so no overrun
    assign wr_do    = w_ev & ~sy3_r[`FFTM_SY_WEN] & (mem_cnt_r != depth);
    // Fall-through loads a parked word only after the three-edge settle
    assign rd_do    = r_ev & mem_ne & (fw ? (output_ready_n ? ne_s2_r : ~sy3_r[`FFTM_SY_REN])
                                         : ~sy3_r[`FFTM_SY_REN]);
    assign din_w    = bus9_r ? {9'h000, sy3_r[`FFTM_SY_DIN +: `FFTM_D9W]}
                             : sy3_r[`FFTM_SY_DIN +: `FFTM_DW];

    always_ff @(posedge mclk) begin
        if (wr_do) begin
            mem[wptr_r] <= din_w;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wptr_r    <= 12'h000;
            rptr_r    <= 12'h000;
            mem_cnt_r <= 13'h0000;
        end else begin
            if (wr_do) begin
                wptr_r <= ptr_step(wptr_r, depth);
            end
            if (rd_do) begin
                rptr_r <= ptr_step(rptr_r, depth);
            end
            unique case ({wr_do, rd_do})
                2'b10:   mem_cnt_r <= mem_cnt_r + 13'h0001;
                2'b01:   mem_cnt_r <= mem_cnt_r - 13'h0001;
                default: mem_cnt_r <= mem_cnt_r;
            endcase
        end
    end

    // ****************************************************************
    // Read data and output register
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            dout <= 18'h00000;
        end else if (rd_do) begin
            dout <= mem[rptr_r];
        end
    end

    // Output-ready is itself the valid bit of the output register
    always_ff @(posedge mclk) begin
        if (srst) begin
            output_ready_n <= 1'b1;
            ne_s1_r        <= 1'b0;
            ne_s2_r        <= 1'b0;
        end else if (r_ev && fw) begin
            ne_s1_r <= mem_ne & output_ready_n;
            ne_s2_r <= ne_s1_r & output_ready_n;
            if (rd_do) begin
                output_ready_n <= 1'b0;
            end else if (!sy3_r[`FFTM_SY_REN]) begin
                output_ready_n <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Empty, full and input-ready flags
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            ef1_r      <= 1'b0;
            empty_flag <= 1'b0;
        end else if (r_ev) begin
            ef1_r      <= ~fw & (tot != 13'h0000);
            empty_flag <= ef1_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ff1_r     <= 1'b1;
            full_flag <= 1'b1;
        end else if (w_ev) begin
            ff1_r     <= fw | ~full_lvl;
            full_flag <= ff1_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ir1_r         <= 1'b0;
            input_ready_n <= 1'b0;
        end else if (w_ev) begin
            ir1_r         <= fw & full_lvl;
            input_ready_n <= ir1_r;
        end
    end

    // ****************************************************************
    // Programmable and half-full flags
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            almost_empty_flag <= 1'b0;
            half_full_flag    <= 1'b1;
            almost_full_flag  <= 1'b1;
        end else begin
            almost_empty_flag <= (tot >= thr(n_r + 13'h0001, fw));
            half_full_flag    <= ~(tot >= thr({1'b0, depth[`FFTM_CW-1:1]} + 13'h0001, fw));
            // Same compare in both directions, so reads release at one threshold
            almost_full_flag  <= ~(tot >= thr(depth - m_r, fw));
        end
    end
    // Half-full threshold above

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            n_r <= `FFTM_OFFS_DEF;
            m_r <= `FFTM_OFFS_DEF;
        end else if (regs.wr_stb && regs.wr_addr == `FFTM_REG_OFFS) begin
            if (regs.wr_strb[0]) n_r[7:0]  <= regs.wr_data[7:0];
            if (regs.wr_strb[1]) n_r[12:8] <= regs.wr_data[12:8];
            if (regs.wr_strb[2]) m_r[7:0]  <= regs.wr_data[23:16];
            if (regs.wr_strb[3]) m_r[12:8] <= regs.wr_data[28:24];
        end
    end

    // Status is read only: writes there are dropped with OKAY
    assign regs.wr_err = (regs.wr_addr != `FFTM_REG_OFFS) && (regs.wr_addr != `FFTM_REG_STAT);

    always_comb begin
        regs.rd_err  = 1'b0;
        regs.rd_data = 32'h0000_0000;
        unique case (regs.rd_addr)
            `FFTM_REG_OFFS: regs.rd_data = {3'h0, m_r, 3'h0, n_r};
            `FFTM_REG_STAT: regs.rd_data = {3'h0, tot, 7'h00, bus9_r, fw, input_ready_n,
                                            output_ready_n, almost_full_flag, half_full_flag,
                                            almost_empty_flag, full_flag, empty_flag};
            default:        regs.rd_err  = 1'b1;
        endcase
    end

    fftm_axil_slave u_axil (
        .mclk          (mclk),
        .srst          (srst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs.bus)
    );

endmodule

// ===== fifo_flag_timing_modes_test.sv
`timescale 1ns/1ps

// **********
// Bench
// **********
module fifo_flag_timing_modes_test;
    import fftm_pkg::*;
    logic        mclk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, wclk, wen_n, rclk, ren_n, mode_select_serial_in, bus9_select;
    logic        empty_flag, full_flag, output_ready_n, input_ready_n;
    logic        almost_empty_flag, half_full_flag, almost_full_flag;
    fftm_addr_t  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rs, exp_r[$];
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    fftm_word_t  din, dout, prev_d, w, exp_d[$];
    int          bad_count = 0;
    int          total_checks = 0;

    fftm_top DUT (.*);
    fftm_far_end u_far (.*);

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task settle;
        repeat (48) @(posedge mclk);
    endtask
    task rst(input logic m, input logic b);
        srst                  <= 1'b1;
        mode_select_serial_in <= m;
        bus9_select           <= b;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        settle;
    endtask
    // Resp in bits 31:30 so one queue serves both channels
    task axw(input fftm_addr_t a, input logic [31:0] d, input logic [31:0] e);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        exp_r.push_back(e);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            aw_ok |= (s_axi_awready === 1'b1);
            w_ok  |= (s_axi_wready === 1'b1);
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid  <= !w_ok;
        end
        @(posedge mclk);
        while (s_axi_bvalid !== 1'b1) @(posedge mclk);
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask
    task axr(input fftm_addr_t a, input logic [31:0] e);
        exp_r.push_back(e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        @(posedge mclk);
        while (s_axi_arready !== 1'b1) @(posedge mclk);
        s_axi_arvalid <= 1'b0;
        @(posedge mclk);
        while (s_axi_rvalid !== 1'b1) @(posedge mclk);
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
            check(s_axi_bvalid ? {s_axi_bresp, 30'h0} : {s_axi_rresp, s_axi_rdata[29:0]},
                  exp_r.pop_front());
    end
    // Any dout move with no word owed is a read that should have been ignored
    always @(negedge mclk) begin
        if (srst) prev_d = dout;
        else if (dout !== prev_d) begin
            check({14'h0, dout}, {14'h0, exp_d.pop_front()});
            prev_d = dout;
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #900000;
        bad_count++;
        stop_test;
    end
    initial begin
        rs = $urandom(62605);
        {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {mode_select_serial_in, bus9_select, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        rst(1'b0, 1'b0);
        axr(8'h04, 32'h0000003A);
        axr(8'h00, 32'h007F007F);
        axw(8'h08, 32'h0, 32'h80000000);
        axr(8'h0C, 32'h80000000);
        axw(8'h00, 32'h00030002, 32'h0);
        axr(8'h00, 32'h00030002);
        for (int i = 0; i < 2049; i++) begin
            rs = $urandom();
            w  = {rs[9:0], i[7:0]};
            u_far.wq.push_back(w);
            if (i < 2048) exp_d.push_back(w);
        end
        while (u_far.wq.size() != 0) @(posedge mclk);
        settle;
        axr(8'h04, 32'h08000025);
        u_far.rd_pend = 2049;
        while (u_far.rd_pend != 0) @(posedge mclk);
        settle;
        axr(8'h04, 32'h0000003A);
        rst(1'b1, 1'b1);
        rs = $urandom();
        w  = {rs[17:1], 1'b1};
        u_far.wq.push_back(w);
        exp_d.push_back({9'h0, w[8:0]});
        while (u_far.wq.size() != 0) @(posedge mclk);
        settle;
        axr(8'h04, 32'h0001019A);
        u_far.rd_pend = 1;
        settle;
        axr(8'h04, 32'h000001BA);
        check(exp_d.size() + exp_r.size(), 32'h0);
        stop_test;
    end
endmodule
